// ==== src/xmem_defines.vh ====
// Constants for the external program memory bus controller.
`ifndef XMEM_DEFINES_VH
`define XMEM_DEFINES_VH

`define MC_CLOCKS          4
`define INT_ROM_BYTES      32768
`define FETCH_MCYCLES      2
`define XDM_MIN_MCYCLES    2
`define XDM_MAX_MCYCLES    9
`define RST_HOLD_MCYCLES   2
`define RST_HOLD_CLOCKS    (`RST_HOLD_MCYCLES * `MC_CLOCKS)
`define ADDR_HOLD_CLOCKS   2
`define STROBE_TAIL_CLOCKS 2

`endif

// ==== src/pin_sync.v ====
// Two-stage synchroniser for pins entering the mclk domain.
`timescale 1ns/1ps
module pin_sync #(
    parameter             WIDTH     = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    // Clock and reset
    input  wire             mclk,
    input  wire             arst_n,
    // Pin side
    input  wire [WIDTH-1:0] pin,
    // Synchronised side
    output reg  [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta;

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= RESET_VAL;
            q    <= RESET_VAL;
        end else begin
            meta <= pin;
            q    <= meta;
        end
    end
endmodule

// ==== src/program_memory_bus.v ====
// External program and data memory bus sequencer with machine-cycle timing and reset-pin qualifier.
`timescale 1ns/1ps
`include "xmem_defines.vh"
module program_memory_bus #(
    parameter CNT_W = 6
) (
    // Clock and reset
    input  wire        mclk,
    input  wire        arst_n,
    // Device pins
    input  wire        external_fetch_select,
    input  wire        reset_pin,
    input  wire [7:0]  p0_in,
    output reg  [7:0]  p0_out,
    output reg         p0_oe,
    output reg  [7:0]  p2_out,
    output reg         p2_oe,
    output reg         ale,
    output reg         program_fetch_strobe_n,
    output reg         wr_strobe_n,
    output reg         rd_strobe_n,
    // Core fetch port (instruction fetch or code_table_read)
    input  wire        fetch_req,
    input  wire [15:0] fetch_addr,
    input  wire        fetch_is_table,
    output wire        fetch_ready,
    // Core external_data_move port
    input  wire        xdm_req,
    input  wire        xdm_write,
    input  wire [15:0] xdm_addr,
    input  wire [7:0]  xdm_wdata,
    input  wire [2:0]  xdm_stretch,
    output wire        xdm_ready,
    // Internal ROM port
    output reg  [14:0] int_rom_addr,
    output reg         int_rom_rd,
    input  wire [7:0]  int_rom_data,
    // Results and status
    output reg         done,
    output reg  [7:0]  rd_data,
    output reg         done_was_fetch,
    output reg         device_reset,
    output reg  [1:0]  mcycle_phase,
    output reg         ext_cycle
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_INT  = 3'h1;
    localparam [2:0] ST_EXT  = 3'h2;

    localparam integer     LAST_PHASE_I = `MC_CLOCKS - 1;
    localparam integer     INT_LAST_I   = `MC_CLOCKS - 2;
    localparam integer     FETCH_LAST_I = `FETCH_MCYCLES * `MC_CLOCKS - 1;
    localparam integer     ADDR_END_I   = `ADDR_HOLD_CLOCKS;
    localparam integer     TAIL_I       = `STROBE_TAIL_CLOCKS;
    localparam integer     RST_CLOCKS_I = `RST_HOLD_CLOCKS;
    localparam integer     XDM_BASE_I   = `XDM_MIN_MCYCLES * `MC_CLOCKS - 1;
    localparam integer     ROM_LIMIT_I  = `INT_ROM_BYTES;

    localparam [1:0]       LAST_PHASE  = LAST_PHASE_I[1:0];
    localparam [CNT_W-1:0] INT_LAST    = INT_LAST_I[CNT_W-1:0];
    localparam [CNT_W-1:0] FETCH_LAST  = FETCH_LAST_I[CNT_W-1:0];
    localparam [CNT_W-1:0] ADDR_END    = ADDR_END_I[CNT_W-1:0];
    localparam [CNT_W-1:0] TAIL        = TAIL_I[CNT_W-1:0];
    localparam [CNT_W-1:0] RST_CLOCKS  = RST_CLOCKS_I[CNT_W-1:0];
    localparam [CNT_W-1:0] XDM_BASE    = XDM_BASE_I[CNT_W-1:0];
    localparam [15:0]      ROM_LIMIT   = ROM_LIMIT_I[15:0];

    wire       ea_q;
    wire       rst_q;
    wire [7:0] p0_q;

    pin_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_sync_ea (
        .mclk   (mclk),
        .arst_n (arst_n),
        .pin    (external_fetch_select),
        .q      (ea_q)
    );
    pin_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_sync_rst (
        .mclk   (mclk),
        .arst_n (arst_n),
        .pin    (reset_pin),
        .q      (rst_q)
    );
    pin_sync #(.WIDTH(8), .RESET_VAL(8'h00)) u_sync_p0 (
        .mclk   (mclk),
        .arst_n (arst_n),
        .pin    (p0_in),
        .q      (p0_q)
    );

    // ------------------------------------------------------------------
    // Reset pin qualifier
    // ------------------------------------------------------------------
    // A short glitch on the pin must not reset the device, so the level
    // has to be seen for a full hold window before it takes effect.
    reg [CNT_W-1:0] rst_cnt;

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_cnt      <= {CNT_W{1'b0}};
            device_reset <= 1'b0;
        end else if (!rst_q) begin
            rst_cnt      <= {CNT_W{1'b0}};
            device_reset <= 1'b0;
        end else if (rst_cnt < RST_CLOCKS - 1'b1) begin
            rst_cnt      <= rst_cnt + 1'b1;
        end else begin
            device_reset <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Machine cycle phase
    // ------------------------------------------------------------------
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mcycle_phase <= 2'h0;
        end else if (device_reset) begin
            mcycle_phase <= 2'h0;
        end else if (mcycle_phase == LAST_PHASE) begin
            mcycle_phase <= 2'h0;
        end else begin
            mcycle_phase <= mcycle_phase + 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------------
    reg  [2:0]       state;
    reg  [CNT_W-1:0] cnt;
    reg  [CNT_W-1:0] last;
    reg  [1:0]       kind;
    reg  [7:0]       wdata;

    localparam [1:0] K_FETCH = 2'h0;
    localparam [1:0] K_READ  = 2'h1;
    localparam [1:0] K_WRITE = 2'h2;

    // Requests start only on a machine-cycle boundary; data moves win.
    wire slot_free = (state == ST_IDLE) && !device_reset && (mcycle_phase == 2'h0);
    assign xdm_ready   = slot_free;
    assign fetch_ready = slot_free && !xdm_req;

    wire fetch_ext = !ea_q || (fetch_addr >= ROM_LIMIT);
    wire [CNT_W-1:0] xdm_last = XDM_BASE + {{(CNT_W-5){1'b0}}, xdm_stretch, 2'b00};

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state                  <= ST_IDLE;
            cnt                    <= {CNT_W{1'b0}};
            last                   <= {CNT_W{1'b0}};
            kind                   <= K_FETCH;
            wdata                  <= 8'h00;
            p0_out                 <= 8'h00;
            p0_oe                  <= 1'b0;
            p2_out                 <= 8'h00;
            p2_oe                  <= 1'b0;
            ale                    <= 1'b0;
            program_fetch_strobe_n <= 1'b1;
            wr_strobe_n            <= 1'b1;
            rd_strobe_n            <= 1'b1;
            int_rom_addr           <= 15'h0000;
            int_rom_rd             <= 1'b0;
            done                   <= 1'b0;
            rd_data                <= 8'h00;
            done_was_fetch         <= 1'b0;
            ext_cycle              <= 1'b0;
        end else begin
            done       <= 1'b0;
            int_rom_rd <= 1'b0;
            case (state)
                ST_IDLE: begin
                    ale                    <= 1'b0;
                    p0_oe                  <= 1'b0;
                    p2_oe                  <= 1'b0;
                    program_fetch_strobe_n <= 1'b1;
                    wr_strobe_n            <= 1'b1;
                    rd_strobe_n            <= 1'b1;
                    cnt                    <= {CNT_W{1'b0}};
                    if (xdm_ready && xdm_req) begin
                        state     <= ST_EXT;
                        kind      <= xdm_write ? K_WRITE : K_READ;
                        last      <= xdm_last;
                        wdata     <= xdm_wdata;
                        ext_cycle <= 1'b1;
                        ale       <= 1'b1;
                        p0_out    <= xdm_addr[7:0];
                        p0_oe     <= 1'b1;
                        p2_out    <= xdm_addr[15:8];
                        p2_oe     <= 1'b1;
                    end else if (fetch_ready && fetch_req && fetch_ext) begin
                        state     <= ST_EXT;
                        kind      <= K_FETCH;
                        last      <= FETCH_LAST;
                        ext_cycle <= 1'b1;
                        ale       <= 1'b1;
                        p0_out    <= fetch_addr[7:0];
                        p0_oe     <= 1'b1;
                        p2_out    <= fetch_addr[15:8];
                        p2_oe     <= 1'b1;
                    end else if (fetch_ready && fetch_req) begin
                        state        <= ST_INT;
                        ext_cycle    <= 1'b0;
                        int_rom_addr <= fetch_addr[14:0];
                        int_rom_rd   <= 1'b1;
                    end
                end
                ST_INT: begin
                    // Internal reads keep every pin quiet, strobe included.
                    program_fetch_strobe_n <= 1'b1;
                    cnt <= cnt + 1'b1;
                    if (cnt == INT_LAST) begin
                        state          <= ST_IDLE;
                        done           <= 1'b1;
                        rd_data        <= int_rom_data;
                        done_was_fetch <= 1'b1;
                    end
                end
                ST_EXT: begin
                    cnt <= cnt + 1'b1;
                    ale <= 1'b0;
                    if (cnt + 1'b1 >= ADDR_END) begin
                        // Address phase over: port turns round to data.
                        p0_oe  <= (kind == K_WRITE);
                        p0_out <= (kind == K_WRITE) ? wdata : 8'h00;
                    end
                    program_fetch_strobe_n <= !((kind == K_FETCH) && strobe_next(cnt));
                    rd_strobe_n            <= !((kind == K_READ) && strobe_next(cnt));
                    wr_strobe_n            <= !((kind == K_WRITE) && strobe_next(cnt));
                    // Pin data passes two flops, so the byte taken at the strobe's trailing
                    // edge was on the pins two clocks earlier, inside the window.
                    if (kind != K_WRITE && cnt == last - TAIL) begin
                        rd_data <= p0_q;
                    end
                    if (cnt == last) begin
                        state                  <= ST_IDLE;
                        done                   <= 1'b1;
                        done_was_fetch         <= (kind == K_FETCH);
                        p0_oe                  <= 1'b0;
                        p2_oe                  <= 1'b0;
                        program_fetch_strobe_n <= 1'b1;
                        rd_strobe_n            <= 1'b1;
                        wr_strobe_n            <= 1'b1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
            if (device_reset) begin
                state                  <= ST_IDLE;
                done                   <= 1'b0;
                ale                    <= 1'b0;
                p0_oe                  <= 1'b0;
                p2_oe                  <= 1'b0;
                program_fetch_strobe_n <= 1'b1;
                rd_strobe_n            <= 1'b1;
                wr_strobe_n            <= 1'b1;
            end
        end
    end

    // True when the clock after count c lies inside the strobe window.
    function strobe_next;
        input [CNT_W-1:0] c;
        begin
            strobe_next = (c + 1'b1 >= ADDR_END) && (c + 1'b1 <= last - TAIL);
        end
    endfunction
endmodule

// ==== test/program_memory_bus_assertions.sv ====
// Concurrent checks on the external program memory bus ports.
`timescale 1ns/1ps
module program_memory_bus_assertions #(
    parameter CNT_W = 6
) (
    // Clock and reset
    input wire       mclk,
    input wire       arst_n,
    // Pins
    input wire       reset_pin,
    input wire       p0_oe,
    input wire       p2_oe,
    input wire       ale,
    input wire       program_fetch_strobe_n,
    input wire       wr_strobe_n,
    input wire       rd_strobe_n,
    // Core side
    input wire       fetch_ready,
    input wire       xdm_ready,
    input wire       int_rom_rd,
    input wire       done,
    input wire       done_was_fetch,
    input wire       device_reset,
    input wire [1:0] mcycle_phase
);
    // ----------------------------------------------------------------
    // Bus timing checks
    // ----------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    AST_ALE_ADDR: assert property (ale |-> p0_oe && p2_oe ##1 !ale)
        else $error("latch strobe without address or longer than one clock");
    AST_STROBE_LEN: assert property ($fell(program_fetch_strobe_n) |-> !program_fetch_strobe_n[*4] ##1 program_fetch_strobe_n)
        else $error("fetch strobe not four clocks long");
    AST_STROBE_AFTER_ALE: assert property ($fell(program_fetch_strobe_n) |-> $past(ale, 2) && !p0_oe && p2_oe)
        else $error("fetch strobe not two clocks after latch strobe on a freed low port");
    AST_FETCH_DONE: assert property ($fell(program_fetch_strobe_n) |-> ##6 (done && done_was_fetch))
        else $error("external fetch did not finish on time");
    AST_INT_QUIET: assert property (int_rom_rd |-> (program_fetch_strobe_n && !ale && !p0_oe)[*4])
        else $error("pin activity during internal fetch");
    // Two settled cycles are needed after reset, since the phase is held while in reset.
    AST_PHASE: assert property ($past(arst_n, 2) && !device_reset && !$past(device_reset) && !$past(device_reset, 2)
        |-> mcycle_phase == $past(mcycle_phase) + 2'h1)
        else $error("machine cycle phase did not advance by one");
    AST_WR_STROBE: assert property ($fell(wr_strobe_n) |-> p0_oe && p2_oe && program_fetch_strobe_n)
        else $error("write strobe without data driven");
    AST_RD_STROBE: assert property ($fell(rd_strobe_n) |-> !p0_oe && wr_strobe_n)
        else $error("read strobe while low port driven");
    AST_RESET_IDLE: assert property (device_reset |-> !fetch_ready && !xdm_ready && !ale)
        else $error("accesses accepted during reset");
    AST_RESET_QUAL: assert property ($rose(device_reset) |-> $past(reset_pin, 3) && $past(reset_pin, 8))
        else $error("reset entered without a held reset pin");
endmodule

bind program_memory_bus program_memory_bus_assertions #(.CNT_W(CNT_W)) u_chk (
    .mclk(mclk), .arst_n(arst_n), .reset_pin(reset_pin), .p0_oe(p0_oe), .p2_oe(p2_oe), .ale(ale),
    .program_fetch_strobe_n(program_fetch_strobe_n), .wr_strobe_n(wr_strobe_n), .rd_strobe_n(rd_strobe_n),
    .fetch_ready(fetch_ready), .xdm_ready(xdm_ready), .int_rom_rd(int_rom_rd), .done(done),
    .done_was_fetch(done_was_fetch), .device_reset(device_reset), .mcycle_phase(mcycle_phase));

// ==== test/ext_rom_model.sv ====
// External program ROM with address latch and a small data RAM.
`timescale 1ns/1ps
module ext_rom_model (
    // Clock
    input  wire       mclk,
    // Bus from the device
    input  wire       ale,
    input  wire [7:0] p0_out,
    input  wire       p0_oe,
    input  wire [7:0] p2_out,
    input  wire       pfs_n,
    input  wire       rd_n,
    input  wire       wr_n,
    // Resolved low port level
    output wire [7:0] p0_in
);
    reg  [7:0] lo = 8'h00;
    reg  [7:0] last = 8'h00;
    reg  [7:0] mem [0:255];
    wire       drv = !pfs_n || !rd_n;
    wire [7:0] dat = !pfs_n ? (lo ^ p2_out ^ 8'h5A) : mem[lo];
    // No pull-ups in bus mode, so a released port toggles instead of holding the old byte.
    assign p0_in = p0_oe ? p0_out : drv ? dat : ~last;
    always @(posedge mclk) last <= p0_in;
    always @(negedge ale) lo <= p0_out;
    always @(posedge wr_n) mem[lo] <= p0_out;
endmodule

// ==== test/program_memory_bus_tb.sv ====
// Self-checking bench for the external program memory bus.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((e) !== (g)) begin n_mismatch++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module program_memory_bus_tb;
    typedef struct packed { bit f; bit x; bit dc; logic [7:0] d; int lat; int t; } note_t;
    reg         mclk = 1'b0;
    reg         arst_n = 1'b0;
    reg         sel = 1'b1;
    reg         reset_pin = 1'b0;
    reg         fetch_req = 1'b0;
    reg  [15:0] fetch_addr = 16'h0000;
    reg         fetch_is_table = 1'b0;
    reg         xdm_req = 1'b0;
    reg         xdm_write = 1'b0;
    reg  [15:0] xdm_addr = 16'h0000;
    reg  [7:0]  xdm_wdata = 8'h00;
    reg  [2:0]  xdm_stretch = 3'h0;
    wire [7:0]  p0_in, p0_out, p2_out, rd_data;
    wire [14:0] int_rom_addr;
    wire [1:0]  mcycle_phase;
    wire        p0_oe, p2_oe, ale, pfs_n, wr_n, rd_n, fetch_ready, xdm_ready, int_rom_rd;
    wire        done, done_was_fetch, device_reset, ext_cycle;
    wire [7:0]  int_rom_data = int_rom_addr[7:0] ^ 8'hC3;
    int         n_mismatch = 0;
    int         check_count = 0;
    int         cyc = 0;
    reg  [15:0] rs = 16'h000F;
    note_t      q[$];

    program_memory_bus #(.CNT_W(6)) u_dut (
        .mclk(mclk), .arst_n(arst_n), .external_fetch_select(sel), .reset_pin(reset_pin),
        .p0_in(p0_in), .p0_out(p0_out), .p0_oe(p0_oe), .p2_out(p2_out), .p2_oe(p2_oe), .ale(ale),
        .program_fetch_strobe_n(pfs_n), .wr_strobe_n(wr_n), .rd_strobe_n(rd_n), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .fetch_is_table(fetch_is_table), .fetch_ready(fetch_ready), .xdm_req(xdm_req),
        .xdm_write(xdm_write), .xdm_addr(xdm_addr), .xdm_wdata(xdm_wdata), .xdm_stretch(xdm_stretch),
        .xdm_ready(xdm_ready), .int_rom_addr(int_rom_addr), .int_rom_rd(int_rom_rd), .int_rom_data(int_rom_data),
        .done(done), .rd_data(rd_data), .done_was_fetch(done_was_fetch), .device_reset(device_reset),
        .mcycle_phase(mcycle_phase), .ext_cycle(ext_cycle));
    ext_rom_model u_rom (.mclk(mclk), .ale(ale), .p0_out(p0_out), .p0_oe(p0_oe), .p2_out(p2_out),
        .pfs_n(pfs_n), .rd_n(rd_n), .wr_n(wr_n), .p0_in(p0_in));

    always #25 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;

    function automatic [15:0] xs();
        rs = rs ^ (rs << 7);
        rs = rs ^ (rs >> 9);
        rs = rs ^ (rs << 8);
        return rs;
    endfunction

    task summarize();
        if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Driver notes each expectation when the request is taken
    // ----------------------------------------------------------------
    task automatic acc(input bit x, input bit w, input [15:0] a, input [7:0] d, input [2:0] s);
        note_t n;
        int k;
        @(negedge mclk);
        if (x) {xdm_req, xdm_write, xdm_addr, xdm_wdata, xdm_stretch} = {1'b1, w, a, d, s};
        else {fetch_req, fetch_addr, fetch_is_table} = {1'b1, a, a[0]};
        k = 0;
        // Ready is settled at the falling edge, so the take happens at the next rising edge.
        while ((x ? xdm_ready : fetch_ready) !== 1'b1 && k < 99) begin
            @(negedge mclk);
            k++;
        end
        if (k == 99) n_mismatch++;
        @(posedge mclk);
        n.f = !x;
        n.x = x || !sel || a[15];
        n.dc = !(x && w);
        n.d = x ? d : n.x ? (a[7:0] ^ a[15:8] ^ 8'h5A) : (a[7:0] ^ 8'hC3);
        n.lat = x ? 4 * (2 + s) : n.x ? 8 : 3;
        @(negedge mclk);
        n.t = cyc;
        q.push_back(n);
        {fetch_req, xdm_req} = 2'b00;
    endtask

    always @(negedge mclk) begin
        note_t n;
        if (done === 1'b1 && q.size() == 0) `CHK("spare done", 1'b0, 1'b1)
        else if (done === 1'b1) begin
            n = q.pop_front();
            `CHK("kind", n.f, done_was_fetch)
            `CHK("external", n.x, ext_cycle)
            if (n.dc) `CHK("data", n.d, rd_data)
            if (n.lat != 0) `CHK("latency", n.lat, cyc - n.t)
        end
    end

    initial begin
        int i;
        reg [15:0] r;
        repeat (10) @(negedge mclk);
        arst_n = 1'b1;
        acc(0, 0, 16'h7FFF, 8'h00, 3'h0);
        acc(0, 0, 16'h8000, 8'h00, 3'h0);
        for (i = 0; i < 16; i++) begin
            if (i % 8 == 0) begin
                sel = (i >= 8);
                repeat (4) @(negedge mclk);
            end
            acc(0, 0, xs(), 8'h00, 3'h0);
        end
        for (i = 0; i < 8; i++) begin
            r = xs();
            acc(1, 1, r, r[15:8], i[2:0]);
            acc(1, 0, r, r[15:8], 3'h7 - i[2:0]);
        end
        reset_pin = 1'b1;
        repeat (4) @(negedge mclk);
        reset_pin = 1'b0;
        repeat (12) @(negedge mclk);
        `CHK("short reset", 1'b0, device_reset)
        reset_pin = 1'b1;
        repeat (16) @(negedge mclk);
        `CHK("long reset", 1'b1, device_reset)
        `CHK("ready in reset", 1'b0, fetch_ready)
        reset_pin = 1'b0;
        repeat (8) @(negedge mclk);
        `CHK("reset release", 1'b0, device_reset)
        acc(0, 0, 16'hC0DE, 8'h00, 3'h0);
        repeat (20) @(negedge mclk);
        `CHK("pending", 0, q.size())
        summarize();
    end

    initial begin
        #200000;
        n_mismatch++;
        summarize();
    end
endmodule
